//--- inc/coord_pkg.sv
// constants for the multiprocessor coordinator control block
// assumes a 200 MHz core clock; bus strobes are synchronous single-cycle or level
package coord_pkg;
	localparam int         CLK_PERIOD_NS     = 5;
	localparam int         LOCK_LIMIT_MS     = 2;
	localparam int         LOCK_LIMIT_CYCLES = LOCK_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [15:0] FAULT_ADDR       = 16'hfeff;
	localparam logic [15:0] FLAG_BASE        = 16'hf200;
	localparam logic [7:0]  FLAG_HI_BYTE     = 8'hf2;
	localparam int         FLAG_BLOCK_LSB    = 5;
	localparam int         NUM_CPU_MAX       = 4;
	localparam int         NUM_SLOTS         = 8;
	localparam logic [4:0]  BASE_MIN         = 5'h01;
	localparam logic [2:0]  CPU_SEL_TWO      = 3'h1;
	localparam logic [2:0]  CPU_SEL_THREE    = 3'h2;
	localparam logic [2:0]  CPU_SEL_FOUR     = 3'h4;
	localparam logic [7:0]  PAGE_RESET       = 8'h00;
	localparam logic [7:0]  FAULT_RESET      = 8'h00;
	typedef enum logic [1:0] {MODE_STOP, MODE_RUN, MODE_TEST} mode_sel_type;
	typedef enum {ST_HOLD, ST_CYCLE} run_state_type;
endpackage : coord_pkg

//--- inc/slot_sel_if.sv
// selection bundle between the control top and the serial multiplexer
// assumes one core clock domain
`timescale 1ns/1ps
`default_nettype none
interface slot_sel_if;
	logic       valid;
	logic [2:0] index;
	modport src (output valid, output index);
	modport dst (input valid, input index);
endinterface : slot_sel_if
`default_nettype wire

//--- hdl/prog_port_mux.sv
// programmer serial port multiplexer onto eight backplane channels
// assumes selection arrives via slot_sel_if, serial lines synchronous
`timescale 1ns/1ps
`default_nettype none
module prog_port_mux (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	slot_sel_if.dst         sel,
	input  wire logic       i_prog_txd,
	output logic            o_prog_rxd,
	input  wire logic [7:0] i_slot_rxd,
	output logic [7:0]      o_slot_txd
);
	import coord_pkg::*;
	logic [7:0] next_slot_txd;
	logic       next_prog_rxd;
	// ********************
	// routing
	// ********************
	always_comb begin
		next_slot_txd = 8'hff; // idle line is mark
		next_prog_rxd = 1'b1;
		for (int k = 0; k < NUM_SLOTS; k++) begin
			if (sel.valid && sel.index == 3'(k)) begin
				next_slot_txd[k] = i_prog_txd;
				next_prog_rxd    = i_slot_rxd[k];
			end
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_slot_txd <= 8'hff;
			o_prog_rxd <= 1'b1;
		end else begin
			o_slot_txd <= next_slot_txd;
			o_prog_rxd <= next_prog_rxd;
		end
	end
	idle_slots_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!sel.valid |=> o_slot_txd == 8'hff) else $error("unselected channel not idle");
endmodule : prog_port_mux
`default_nettype wire

//--- hdl/lock_watchdog.sv
// bus lock watchdog: flags a lock held beyond its limit
// assumes the lock input is synchronous
`timescale 1ns/1ps
`default_nettype none
module lock_watchdog #(
	parameter int LIMIT = coord_pkg::LOCK_LIMIT_CYCLES
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_bus_lock,
	output logic      o_expired
);
	import coord_pkg::*;
	logic [31:0] count;
	logic [31:0] next_count;
	logic        next_expired;
	always_comb begin
		next_count   = count;
		next_expired = o_expired;
		if (!i_bus_lock) begin
			next_count   = 32'h0000_0000;
			next_expired = 1'b0;
		end else if (count >= 32'(LIMIT)) begin
			next_expired = 1'b1;
		end else begin
			next_count = count + 32'h0000_0001;
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			count     <= 32'h0000_0000;
			o_expired <= 1'b0;
		end else begin
			count     <= next_count;
			o_expired <= next_expired;
		end
	end
	no_early_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_expired |-> $past(i_bus_lock)) else $error("expiry without lock");
endmodule : lock_watchdog
`default_nettype wire

//--- hdl/coord_control.sv
// multiprocessor coordinator control: config, fault register, flag decode, modes
// assumes synchronous bus strobes and switch inputs; owner index valid with lock
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - one-hot three switches select two, three or four CPUs; two by default
// - multiplexer base address 1..31 is binary sum of switch weights
// - eight subscriber addresses base..base+7, each fixed to one slot channel
// - only addresses whose activation switch is on are routed
// - flag memory F200..F2FF decoded in eight 32-byte blocks
// - each block masked individually by its own jumper
// - masked blocks not acknowledged, unmasked blocks acknowledged normally
// - coordination disable option drops the stop, output-disable and halt outputs; test-active is not gated
// - 8-bit fault register readable at FEFF
// - lock timeout sets the fault bit of the offending CPU
// - fault register cleared when halt becomes inactive
// - write at FEFF loads page select, read returns fault register
// - page select is 8 bits, write-only, reset to zero
// - lock held beyond 2 ms asserts halt stopping all CPUs
// - stop selector at power-up or any stop request keeps CPUs stopped
// - run selector allows auto restart if CPU selectors run and was cycling
// - test only with test switch; stop to test enters cyclic status
// - in test, output-disable suppressed for CPUs stopped by front switch
// - in test, a running CPU's error stops only it, no output-disable
module coord_control #(
	parameter int LOCK_CYCLES = coord_pkg::LOCK_LIMIT_CYCLES
) (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst,
	input  wire logic [2:0]              i_cpu_count_switch,
	input  wire logic [4:0]              i_mux_base_switch,
	input  wire logic [7:0]              i_slot_activation_switches,
	input  wire logic [7:0]              i_flag_block_jumpers,
	input  wire logic                    i_coord_enable_jumper,
	input  wire logic                    i_test_enable_switch,
	input  wire coord_pkg::mode_sel_type i_mode_sel,
	input  wire logic                    i_stop_request,
	input  wire logic                    i_was_cycling,
	input  wire logic [3:0]              i_cpu_run_sel,
	input  wire logic [3:0]              i_cpu_error,
	input  wire logic                    i_bus_lock,
	input  wire logic [1:0]              i_lock_owner,
	input  wire logic [15:0]             i_addr,
	input  wire logic                    i_mem_rd,
	input  wire logic                    i_mem_wr,
	input  wire logic [7:0]              i_data_wr,
	input  wire logic                    i_subscriber_valid,
	input  wire logic [4:0]              i_subscriber_addr,
	input  wire logic                    i_prog_txd,
	input  wire logic [7:0]              i_slot_rxd,
	output logic [7:0]                   o_data_rd,
	output logic                         o_ack,
	output logic                         o_flag_sel,
	output logic [7:0]                   o_page_select,
	output logic [3:0]                   o_cpu_enabled,
	output logic                         o_halt,
	output logic [3:0]                   o_cpu_stop,
	output logic [3:0]                   o_output_disable_signal,
	output logic                         o_test_active,
	output logic                         o_prog_rxd,
	output logic [7:0]                   o_slot_txd
);
	import coord_pkg::*;

	// ********************
	// decode helpers
	// ********************
	function automatic logic [3:0] cpu_mask(input logic [2:0] sw);
		case (sw)
			CPU_SEL_THREE: cpu_mask = 4'h7;
			CPU_SEL_FOUR:  cpu_mask = 4'hf;
			default:       cpu_mask = 4'h3; // invalid coding falls back to two
		endcase
	endfunction : cpu_mask

	function automatic logic is_flag(input logic [15:0] a);
		is_flag = a[15:8] == FLAG_HI_BYTE;
	endfunction : is_flag

	// ********************
	// configuration and bus
	// ********************
	logic [3:0]  cpu_en;
	logic [7:0]  fault;
	logic [7:0]  page;
	logic        ack;
	logic        flag_sel;
	logic [7:0]  data_rd;
	logic [7:0]  next_fault;
	logic [7:0]  next_page;
	logic        next_ack;
	logic        next_flag_sel;
	logic [7:0]  next_data_rd;
	logic        halt_prev;
	logic        lock_expired;
	logic [2:0]  flag_block;

	assign flag_block = i_addr[7:FLAG_BLOCK_LSB];

	always_comb begin
		next_page     = page;
		next_fault    = fault;
		next_ack      = 1'b0;
		next_flag_sel = 1'b0;
		next_data_rd  = 8'h00;
		if (i_mem_wr && i_addr == FAULT_ADDR) begin
			next_page = i_data_wr;
			next_ack  = 1'b1;
		end
		if (i_mem_rd && i_addr == FAULT_ADDR) begin
			next_data_rd = fault;
			next_ack     = 1'b1;
		end
		if ((i_mem_rd || i_mem_wr) && is_flag(i_addr) && i_flag_block_jumpers[flag_block]) begin
			next_ack      = 1'b1;
			next_flag_sel = 1'b1;
		end
		// halt going inactive clears, but a new timeout in the same cycle wins
		if (halt_prev && !lock_expired)
			next_fault = FAULT_RESET;
		if (lock_expired)
			next_fault[i_lock_owner] = 1'b1;
		next_fault[7:NUM_CPU_MAX] = 4'h0;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			page      <= PAGE_RESET;
			fault     <= FAULT_RESET;
			ack       <= 1'b0;
			flag_sel  <= 1'b0;
			data_rd   <= 8'h00;
			halt_prev <= 1'b0;
			cpu_en    <= 4'h3;
		end else begin
			page      <= next_page;
			fault     <= next_fault;
			ack       <= next_ack;
			flag_sel  <= next_flag_sel;
			data_rd   <= next_data_rd;
			halt_prev <= lock_expired;
			cpu_en    <= cpu_mask(i_cpu_count_switch);
		end
	end

	lock_watchdog #(
		.LIMIT(LOCK_CYCLES)
	) u_watchdog (
		.i_core_clk(i_core_clk),
		.i_rst     (i_rst),
		.i_bus_lock(i_bus_lock),
		.o_expired (lock_expired)
	);

	// ********************
	// operating modes
	// ********************
	run_state_type state;
	run_state_type next_state;
	logic          first_cycle;
	mode_sel_type  prev_sel;
	logic          test_ok;
	logic [3:0]    stop;
	logic [3:0]    odis;
	logic [3:0]    next_stop;
	logic [3:0]    next_odis;

	assign test_ok = i_test_enable_switch;

	always_comb begin
		next_state = state;
		case (state)
			ST_HOLD: begin
				if (first_cycle && i_mode_sel == MODE_RUN && i_was_cycling)
					next_state = ST_CYCLE;
				else if (test_ok && prev_sel == MODE_STOP && i_mode_sel == MODE_TEST)
					next_state = ST_CYCLE;
			end
			ST_CYCLE: begin
				if (i_mode_sel == MODE_STOP || (i_mode_sel == MODE_TEST && !test_ok))
					next_state = ST_HOLD;
			end
			default: next_state = ST_HOLD;
		endcase
		if (i_stop_request || (first_cycle && i_mode_sel == MODE_STOP))
			next_state = ST_HOLD;
		next_stop = 4'hf;
		next_odis = 4'hf;
		if (state == ST_CYCLE && !lock_expired) begin
			next_stop = ~i_cpu_run_sel;
			next_odis = ~i_cpu_run_sel;
			if (test_ok) begin
				next_stop = ~i_cpu_run_sel | i_cpu_error;
				next_odis = 4'h0;
			end else if (|(i_cpu_error & cpu_en)) begin
				next_stop = 4'hf;
				next_odis = 4'hf;
			end
		end
		next_stop = next_stop & cpu_en;
		next_odis = next_odis & cpu_en;
		if (!i_coord_enable_jumper) begin
			next_stop = 4'h0;
			next_odis = 4'h0;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state       <= ST_HOLD;
			first_cycle <= 1'b1;
			prev_sel    <= MODE_STOP;
			stop        <= 4'hf;
			odis        <= 4'hf;
		end else begin
			state       <= next_state;
			first_cycle <= 1'b0;
			prev_sel    <= i_mode_sel;
			stop        <= next_stop;
			odis        <= next_odis;
		end
	end

	// ********************
	// programmer multiplexer
	// ********************
	slot_sel_if sel_bus ();
	logic [4:0] offset;
	logic       next_valid;
	logic [2:0] next_index;
	logic       sel_valid;
	logic [2:0] sel_index;

	assign offset = i_subscriber_addr - i_mux_base_switch;

	always_comb begin
		next_valid = 1'b0;
		next_index = offset[2:0];
		if (i_subscriber_valid && i_mux_base_switch >= BASE_MIN && i_subscriber_addr >= i_mux_base_switch
			&& offset <= 5'h07)
			next_valid = i_slot_activation_switches[offset[2:0]];
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sel_valid <= 1'b0;
			sel_index <= 3'h0;
		end else begin
			sel_valid <= next_valid;
			sel_index <= next_index;
		end
	end

	assign sel_bus.valid = sel_valid;
	assign sel_bus.index = sel_index;

	prog_port_mux u_mux (
		.i_core_clk(i_core_clk),
		.i_rst     (i_rst),
		.sel       (sel_bus.dst),
		.i_prog_txd(i_prog_txd),
		.o_prog_rxd(o_prog_rxd),
		.i_slot_rxd(i_slot_rxd),
		.o_slot_txd(o_slot_txd)
	);

	// ********************
	// outputs, all registered
	// ********************
	logic halt_q;
	logic test_q;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			halt_q <= 1'b0;
			test_q <= 1'b0;
		end else begin
			halt_q <= lock_expired && i_coord_enable_jumper;
			test_q <= test_ok && i_mode_sel == MODE_TEST;
		end
	end

	assign o_data_rd               = data_rd;
	assign o_ack                   = ack;
	assign o_flag_sel              = flag_sel;
	assign o_page_select           = page;
	assign o_cpu_enabled           = cpu_en;
	assign o_halt                  = halt_q;
	assign o_cpu_stop              = stop;
	assign o_output_disable_signal = odis;
	assign o_test_active           = test_q;

	// ********************
	// checks
	// ********************
	masked_noack_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_mem_rd && is_flag(i_addr) && !i_flag_block_jumpers[flag_block]) |=> !o_ack)
		else $error("masked flag block acknowledged");
	fault_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_mem_rd && i_addr == FAULT_ADDR) |=> o_ack && o_data_rd == $past(fault))
		else $error("fault register read wrong");
	fault_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		lock_expired |=> fault[$past(i_lock_owner)]) else $error("fault bit not set");
	fault_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(halt_prev && !lock_expired) |=> fault == 8'h00) else $error("fault not cleared");
	page_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_mem_wr && i_addr == FAULT_ADDR) |=> o_page_select == $past(i_data_wr))
		else $error("page select not loaded");
	stop_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_stop_request && i_coord_enable_jumper) |=> ##1 o_cpu_stop == cpu_en)
		else $error("stop request ignored");
	test_odis_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state == ST_CYCLE && test_ok && !lock_expired) |=> o_output_disable_signal == 4'h0)
		else $error("output disable in test");
	coord_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!i_coord_enable_jumper |=> o_cpu_stop == 4'h0 && !o_halt) else $error("coordination not off");
	upper_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		fault[7:4] == 4'h0) else $error("unused fault bits set");
endmodule : coord_control
`default_nettype wire

//--- tb/slot_echo_model.sv
// far-side model of the eight backplane slot modules on the serial channels
// assumes one core clock; each slot answers on its receive line
`timescale 1ns/1ps
`default_nettype none
module slot_echo_model (
	input  wire logic       i_core_clk,
	input  wire logic [7:0] i_txd,
	output logic [7:0]      o_rxd
);
	// ****************
	// slot loopback
	// ****************
	// inverted echo, so a routed channel returns the complement of the programmer's bit
	always_ff @(posedge i_core_clk) begin
		o_rxd <= ~i_txd;
	end
endmodule : slot_echo_model
`default_nettype wire

//--- tb/tb_coord_control.sv
// bench for coord_control: bus decode, fault register, watchdog, mux, modes
// assumes coord_pkg and slot_sel_if compiled first, slot_echo_model alongside
`timescale 1ns/1ps
`default_nettype none
module tb_coord_control;
	import coord_pkg::*;
	// ****************
	// signals
	// ****************
	localparam int LOCK = 20;
	logic clk = 0, rst = 1, coord_en = 1, test_sw = 0, stop_req = 0, cyc = 0, lock = 0;
	logic rd = 0, wr = 0, sub_v = 0, ptxd = 1, ack, fsel, halt, test_act, prxd;
	logic [2:0] cnt_sw = 3'h1;
	logic [4:0] base = 5'h01, sub_addr = 5'h00;
	logic [7:0] act = 8'h00, jmp = 8'hff, wdat = 8'h00, srxd, stxd, drd, page, p, ex;
	logic [3:0] run_sel = 4'h0, err = 4'h0, en, stop, odis;
	logic [1:0] owner = 2'h0;
	logic [15:0] addr = 16'h0000;
	mode_sel_type mode = MODE_STOP;
	logic [2:0] sels[4] = '{3'h1, 3'h2, 3'h4, 3'h3};
	logic [3:0] ens[4] = '{4'h3, 4'h7, 4'hf, 4'h3};
	logic [8:0] exp_q[$];
	logic [8:0] note;
	int error_cnt = 0, n_compared = 0, i;

	always #2.5 clk = ~clk;

	coord_control #(.LOCK_CYCLES(LOCK)) u_dut (
		.i_core_clk(clk), .i_rst(rst), .i_cpu_count_switch(cnt_sw), .i_mux_base_switch(base),
		.i_slot_activation_switches(act), .i_flag_block_jumpers(jmp), .i_coord_enable_jumper(coord_en),
		.i_test_enable_switch(test_sw), .i_mode_sel(mode), .i_stop_request(stop_req),
		.i_was_cycling(cyc), .i_cpu_run_sel(run_sel), .i_cpu_error(err), .i_bus_lock(lock),
		.i_lock_owner(owner), .i_addr(addr), .i_mem_rd(rd), .i_mem_wr(wr), .i_data_wr(wdat),
		.i_subscriber_valid(sub_v), .i_subscriber_addr(sub_addr), .i_prog_txd(ptxd),
		.i_slot_rxd(srxd), .o_data_rd(drd), .o_ack(ack), .o_flag_sel(fsel), .o_page_select(page),
		.o_cpu_enabled(en), .o_halt(halt), .o_cpu_stop(stop), .o_output_disable_signal(odis),
		.o_test_active(test_act), .o_prog_rxd(prxd), .o_slot_txd(stxd));

	slot_echo_model u_slots (.i_core_clk(clk), .i_txd(stxd), .o_rxd(srxd));

	// ****************
	// tasks
	// ****************
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] expv);
		n_compared++;
		if (seen !== expv) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, expv, seen);
		end
	endtask : chk

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task cyc_n(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc_n

	task do_reset;
		@(posedge clk);
		rst <= 1;
		cyc_n(6);
		rst <= 0;
		cyc_n(3);
	endtask : do_reset

	// one strobe cycle; a note is queued only where an acknowledge is due
	// note top bit: flag-memory select expected with the acknowledge
	task bus(input logic [15:0] a, input logic w, input logic [7:0] d, input logic hit, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		if (hit) exp_q.push_back({a[15:8] == FLAG_HI_BYTE, e});
		@(posedge clk);
		rd <= 0;
		wr <= 0;
	endtask : bus

	// ****************
	// acknowledge monitor
	// ****************
	always @(posedge clk) begin
		if (!rst && ack === 1'b1) begin
			if (exp_q.size() == 0) chk("unexpected ack", 16'h0001, 16'h0000);
			else begin
				note = exp_q.pop_front();
				chk("read data", 16'(drd), 16'(note[7:0]));
				chk("flag select", 16'(fsel), 16'(note[8]));
			end
		end
	end

	// ****************
	// sequence
	// ****************
	initial begin
		void'($urandom(68));
		do_reset();
		chk("page reset", 16'(page), 16'(PAGE_RESET));
		chk("stop at power-up", 16'(stop[1:0]), 16'h0003);
		for (i = 0; i < 4; i++) begin
			cnt_sw <= sels[i];
			cyc_n(3);
			chk("cpu count", 16'(en), 16'(ens[i]));
		end
		cnt_sw <= 3'h1;
		// flag memory: block 0 open, block 7 closed, rest random
		jmp <= {1'b0, 6'($urandom()), 1'b1};
		cyc_n(2);
		for (i = 0; i < 8; i++) bus(16'hf200 + 16'(i * 32) + 16'($urandom_range(31)), i[0], 8'h5a, jmp[i], 8'h00);
		bus(16'hf300, 0, 8'h00, 0, 8'h00);
		bus(16'hf1ff, 0, 8'h00, 0, 8'h00);
		p = 8'($urandom());
		bus(FAULT_ADDR, 1, p, 1, 8'h00);
		cyc_n(1);
		chk("page select", 16'(page), 16'(p));
		bus(FAULT_ADDR, 0, 8'h00, 1, FAULT_RESET);
		// lock held by the second cpu past the limit
		owner <= 2'h1;
		lock <= 1;
		for (i = 0; i < 200 && halt !== 1'b1; i++) @(posedge clk);
		if (halt !== 1'b1) begin
			chk("halt timeout", 16'h0000, 16'h0001);
			close_out();
		end
		chk("halt not early", 16'(i >= LOCK), 16'h0001);
		cyc_n(2);
		bus(FAULT_ADDR, 0, 8'h00, 1, 8'h02);
		lock <= 0;
		cyc_n(4);
		chk("halt released", 16'(halt), 16'h0000);
		bus(FAULT_ADDR, 0, 8'h00, 1, 8'h00);
		cyc_n(2);
		chk("missing ack", 16'(exp_q.size()), 16'h0000);
		// programmer mux with coordination outputs cut off
		coord_en <= 0;
		base <= 5'($urandom_range(23, 1));
		act <= 8'($urandom());
		cyc_n(1); // base must settle before subscriber addresses are formed from it
		for (i = 0; i < 9; i++) begin
			sub_v <= 1;
			sub_addr <= base + 5'(i);
			ptxd <= 1'($urandom());
			cyc_n(6);
			ex = (i < 8 && act[i]) ? (~(8'h01 << i) | (ptxd ? (8'h01 << i) : 8'h00)) : 8'hff;
			chk("slot txd", 16'(stxd), 16'(ex));
			chk("prog rxd", 16'(prxd), 16'((i < 8 && act[i]) ? !ptxd : 1'b1));
		end
		chk("coord off stop", 16'(stop), 16'h0000);
		sub_v <= 0;
		coord_en <= 1;
		// automatic restart from run at power-up
		mode <= MODE_RUN;
		run_sel <= 4'hf;
		cyc <= 1;
		do_reset();
		chk("auto restart", 16'(stop[1:0]), 16'h0000);
		stop_req <= 1;
		cyc_n(3);
		chk("stop request", 16'(stop[1:0]), 16'h0003);
		stop_req <= 0;
		// test operation gated by its switch
		mode <= MODE_STOP;
		cyc_n(3);
		mode <= MODE_TEST;
		cyc_n(3);
		chk("test without switch", 16'(test_act), 16'h0000);
		mode <= MODE_STOP;
		test_sw <= 1;
		cyc_n(3);
		mode <= MODE_TEST;
		cyc_n(3);
		chk("test entered", 16'(test_act), 16'h0001);
		run_sel <= 4'he;
		cyc_n(3);
		chk("front stop no disable", 16'(odis[0]), 16'h0000);
		run_sel <= 4'hf;
		err <= 4'h1;
		cyc_n(3);
		chk("error stops one", 16'(stop[1:0]), 16'h0001);
		chk("error no disable", 16'(odis[1:0]), 16'h0000);
		close_out();
	end
endmodule : tb_coord_control
`default_nettype wire
